/* logic/dcdwp_pkg.sv */
// Shared constants for the two-channel converter write port.
// Assumes both ends run on the same ref_clk and import this package.
package dcdwp_pkg;

	// Layout of the 32-point output image
	localparam int IMG_W = 32;
	localparam int DATA_W = 16;
	localparam int DATA_LSB = 0;
	localparam int SEL1_BIT = 16; // Channel 1 select, low selects
	localparam int SEL2_BIT = 17; // Channel 2 select, low selects
	localparam int SPARE_LSB = 18;
	localparam int SPARE_W = IMG_W - SPARE_LSB;

	// Select line levels
	localparam logic SEL_ON = 1'b0;
	localparam logic SEL_OFF = 1'b1;

	// Code range and current-output scaling, in microamps
	localparam logic [31:0] CODE_MAX = 32'h0000ffff;
	localparam logic [31:0] UA_ZERO = 32'h00000fa0; // 4 mA
	localparam logic [31:0] UA_SPAN = 32'h00003e80; // 16 mA
	localparam int UA_W = 15;

	// BCD digit layout for host-side conversion
	localparam int BCD_DIGITS = 4;
	localparam int BCD_DIGIT_W = 4;
	localparam logic [15:0] BCD_RADIX = 16'h000a;

	// How the host feeds the two channels
	typedef enum logic [1:0] {
		DCDWP_MUX,
		DCDWP_POINTER,
		DCDWP_ONLY1,
		DCDWP_BOTH
	} dcdwp_mode_t;

	// Host sequencer states
	typedef enum logic [1:0] {
		HST_IDLE,
		HST_SECOND,
		HST_CLOSE
	} dcdwp_hstate_t;

endpackage

/* logic/dcdwp_if.sv */
// Output-image link between the scanning host and the converter module.
// Assumes a single clock; the host drives every signal, the module only listens.
`timescale 1ns/1ps
`default_nettype none
interface dcdwp_if;
	import dcdwp_pkg::*;

	// Image word, valid while write_stb is high
	logic [IMG_W-1:0] image;
	// High one cycle per write, two cycles running in a pointer scan: image holds a write
	logic write_stb;
	// One-cycle pulse: the host scan is over
	logic scan_end;

	modport host (
		output image,
		output write_stb,
		output scan_end
	);

	modport device (
		input image,
		input write_stb,
		input scan_end
	);
endinterface
`default_nettype wire

/* logic/dcdwp_device.sv */
// Module end of the write port: latches codes into two channels and
// refreshes both converter outputs once per host scan.
// Assumes the host drives the link from logic on the same ref_clk.
//
// Functional notes
// - Host writes plain binary codes only
// - Select1 low on write loads channel 1
// - Select2 high leaves channel 2 untouched
// - Both selects low load both channels
// - Host alternates channels on the scan toggle
// - Channel 2 scan: select2 low, select1 high
// - Image: 32 points, 16 data, 2 select
// - Multiplexing one channel per scan; pointer both
// - Current equals 4 plus 16 D/65535 mA
// - Low select means selected, high not
// - Both outputs refreshed every scan from held values
`timescale 1ns/1ps
`default_nettype none
module dcdwp_device #(
	parameter bit CURRENT_VARIANT = 1'b1
) (
	input wire logic ref_clk,
	input wire logic rstn,
	dcdwp_if.device link,
	output logic [dcdwp_pkg::DATA_W-1:0] ch1_code,
	output logic [dcdwp_pkg::DATA_W-1:0] ch2_code,
	output logic [dcdwp_pkg::UA_W-1:0] ch1_ua,
	output logic [dcdwp_pkg::UA_W-1:0] ch2_ua,
	output logic refresh,
	output logic ch1_fresh,
	output logic ch2_fresh,
	output logic multi_update,
	output logic spare_set
);
	import dcdwp_pkg::*;

	// Held channel values, separate from the converter registers
	logic [DATA_W-1:0] held1;
	logic [DATA_W-1:0] held2;
	logic [DATA_W-1:0] next_held1;
	logic [DATA_W-1:0] next_held2;
	// Per-scan bookkeeping
	logic pend1;
	logic pend2;
	logic pend_multi;
	logic next_pend1;
	logic next_pend2;
	logic next_pend_multi;
	logic spare_seen;
	logic next_spare_seen;
	// Converter-side registers
	logic [DATA_W-1:0] next_ch1_code;
	logic [DATA_W-1:0] next_ch2_code;
	logic [UA_W-1:0] next_ch1_ua;
	logic [UA_W-1:0] next_ch2_ua;
	logic next_refresh;
	logic next_ch1_fresh;
	logic next_ch2_fresh;
	logic next_multi_update;
	logic next_spare_set;
	// Decoded write
	logic [DATA_W-1:0] wr_data;
	logic wr1;
	logic wr2;
	// Write that carries a nonzero spare point
	logic spare_wr;

	// Code to loop current, all 16 bits kept; exact integer division so
	// the 0 and full-scale codes land on 4 mA and 20 mA with no rounding
	function automatic logic [UA_W-1:0] code_to_ua(input logic [DATA_W-1:0] code);
		logic [31:0] prod;
		logic [31:0] ua;
		prod = {{(32-DATA_W){1'b0}}, code} * UA_SPAN;
		ua = UA_ZERO + prod / CODE_MAX;
		return ua[UA_W-1:0];
	endfunction

	// Pick the image apart; the code is taken as plain binary
	always_comb begin
		wr_data = link.image[DATA_LSB +: DATA_W];
		wr1 = link.write_stb && (link.image[SEL1_BIT] == SEL_ON);
		wr2 = link.write_stb && (link.image[SEL2_BIT] == SEL_ON);
	end

	// Spare points carry no meaning; a nonzero one is only reported, so a
	// host that packs stray bits into the image shows up without harm
	always_comb begin
		spare_wr = link.write_stb && (link.image[SPARE_LSB +: SPARE_W] != '0);
	end

	// Channel latches: a high select leaves its channel as it was, so an
	// image with both selects high changes nothing
	always_comb begin
		next_held1 = held1;
		next_held2 = held2;
		if (wr1) begin
			next_held1 = wr_data;
		end
		if (wr2) begin
			next_held2 = wr_data;
		end
	end

	// Held values survive across scans; only a write with a low select moves them
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			held1 <= '0;
			held2 <= '0;
		end else begin
			held1 <= next_held1;
			held2 <= next_held2;
		end
	end

	// Scan bookkeeping: a write in the very cycle of scan_end still counts
	// toward the closing scan, so no update is ever lost from the report
	always_comb begin
		next_pend1 = pend1 | wr1;
		next_pend2 = pend2 | wr2;
		next_pend_multi = pend_multi | ((pend1 | pend2) & (wr1 | wr2)) | (wr1 & wr2);
		next_spare_seen = spare_seen;
		if (spare_wr) begin
			next_spare_seen = 1'b1;
		end
		if (link.scan_end) begin
			next_pend1 = 1'b0;
			next_pend2 = 1'b0;
			next_pend_multi = 1'b0;
			next_spare_seen = 1'b0;
		end
	end

	// Bookkeeping flags, cleared at every scan end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pend1 <= 1'b0;
			pend2 <= 1'b0;
			pend_multi <= 1'b0;
			spare_seen <= 1'b0;
		end else begin
			pend1 <= next_pend1;
			pend2 <= next_pend2;
			pend_multi <= next_pend_multi;
			spare_seen <= next_spare_seen;
		end
	end

	// Converter refresh: both outputs reload from the held values at every
	// scan end, whether or not a channel got new data
	always_comb begin
		next_ch1_code = ch1_code;
		next_ch2_code = ch2_code;
		next_ch1_ua = ch1_ua;
		next_ch2_ua = ch2_ua;
		next_refresh = 1'b0;
		next_ch1_fresh = ch1_fresh;
		next_ch2_fresh = ch2_fresh;
		next_multi_update = multi_update;
		next_spare_set = spare_set;
		if (link.scan_end) begin
			next_ch1_code = next_held1;
			next_ch2_code = next_held2;
			next_refresh = 1'b1;
			// Fresh flags report which channels took data during this scan
			next_ch1_fresh = pend1 | wr1;
			next_ch2_fresh = pend2 | wr2;
			// More than one write, or one write to both channels, in a scan: pointer or broadcast use
			next_multi_update = pend_multi | ((pend1 | pend2) & (wr1 | wr2)) | (wr1 & wr2);
			// A write landing with scan_end itself still counts for the flag
			next_spare_set = spare_seen | spare_wr;
			// Voltage builds have no current loop, so those outputs stay at zero
			if (CURRENT_VARIANT) begin
				next_ch1_ua = code_to_ua(next_held1);
				next_ch2_ua = code_to_ua(next_held2);
			end else begin
				next_ch1_ua = '0;
				next_ch2_ua = '0;
			end
		end
	end

	// Reset starts the loops at code zero, i.e. 4 mA on the current variant
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ch1_code <= '0;
			ch2_code <= '0;
			ch1_ua <= CURRENT_VARIANT ? UA_ZERO[UA_W-1:0] : '0;
			ch2_ua <= CURRENT_VARIANT ? UA_ZERO[UA_W-1:0] : '0;
			refresh <= 1'b0;
			ch1_fresh <= 1'b0;
			ch2_fresh <= 1'b0;
			multi_update <= 1'b0;
			spare_set <= 1'b0;
		end else begin
			ch1_code <= next_ch1_code;
			ch2_code <= next_ch2_code;
			ch1_ua <= next_ch1_ua;
			ch2_ua <= next_ch2_ua;
			refresh <= next_refresh;
			ch1_fresh <= next_ch1_fresh;
			ch2_fresh <= next_ch2_fresh;
			multi_update <= next_multi_update;
			spare_set <= next_spare_set;
		end
	end

endmodule
`default_nettype wire

/* logic/dcdwp_host.sv */
// Scanning host end: builds the output image each scan, converts BCD
// values to binary and drives the channel selects and the scan toggle.
// Assumes scan_start comes from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module dcdwp_host (
	input wire logic ref_clk,
	input wire logic rstn,
	dcdwp_if.host link,
	input wire logic scan_start,
	input wire dcdwp_pkg::dcdwp_mode_t mode,
	input wire logic bcd_format,
	input wire logic [dcdwp_pkg::DATA_W-1:0] ch1_value,
	input wire logic [dcdwp_pkg::DATA_W-1:0] ch2_value,
	output logic busy,
	output logic alternate_scan_toggle
);
	import dcdwp_pkg::*;

	dcdwp_hstate_t state;
	dcdwp_hstate_t next_state;
	logic [IMG_W-1:0] next_image;
	logic next_write_stb;
	logic next_scan_end;
	logic next_toggle;
	logic [DATA_W-1:0] code1;
	logic [DATA_W-1:0] code2;

	// Four packed BCD digits to binary; the module accepts binary only
	function automatic logic [DATA_W-1:0] to_binary(input logic [DATA_W-1:0] v);
		logic [DATA_W-1:0] acc;
		acc = '0;
		for (int i = BCD_DIGITS - 1; i >= 0; i--) begin
			acc = DATA_W'(acc * BCD_RADIX) + DATA_W'(v[i*BCD_DIGIT_W +: BCD_DIGIT_W]);
		end
		return acc;
	endfunction

	// Image word: data in the low 16 points, two selects above, rest off
	function automatic logic [IMG_W-1:0] image_of(input logic [DATA_W-1:0] code,
			input logic sel1_n, input logic sel2_n);
		logic [IMG_W-1:0] img;
		img = '0;
		img[DATA_LSB +: DATA_W] = code;
		img[SEL1_BIT] = sel1_n;
		img[SEL2_BIT] = sel2_n;
		return img;
	endfunction

	always_comb begin
		code1 = bcd_format ? to_binary(ch1_value) : ch1_value;
		code2 = bcd_format ? to_binary(ch2_value) : ch2_value;
	end

	// Scan sequencer; a scan_start while busy is ignored
	always_comb begin
		next_state = state;
		next_image = link.image;
		next_write_stb = 1'b0;
		next_scan_end = 1'b0;
		next_toggle = alternate_scan_toggle;
		case (state)
			HST_IDLE: begin
				if (scan_start) begin
					next_write_stb = 1'b1;
					next_state = HST_CLOSE;
					case (mode)
						DCDWP_MUX: begin
							// Toggle high writes channel 1, low writes channel 2
							if (alternate_scan_toggle) begin
								next_image = image_of(code1, SEL_ON, SEL_OFF);
							end else begin
								next_image = image_of(code2, SEL_OFF, SEL_ON);
							end
						end
						DCDWP_POINTER: begin
							next_image = image_of(code1, SEL_ON, SEL_OFF);
							next_state = HST_SECOND;
						end
						DCDWP_ONLY1: begin
							next_image = image_of(code1, SEL_ON, SEL_OFF);
						end
						DCDWP_BOTH: begin
							next_image = image_of(code1, SEL_ON, SEL_ON);
						end
						default: begin
							next_image = image_of(code1, SEL_OFF, SEL_OFF);
						end
					endcase
				end
			end
			HST_SECOND: begin
				next_image = image_of(code2, SEL_OFF, SEL_ON);
				next_write_stb = 1'b1;
				next_state = HST_CLOSE;
			end
			HST_CLOSE: begin
				next_scan_end = 1'b1;
				next_toggle = ~alternate_scan_toggle; // On one scan, off the next
				next_state = HST_IDLE;
			end
			default: begin
				next_state = HST_IDLE;
			end
		endcase
	end

	// Reset image has both selects off so a stray strobe changes nothing; after a scan the last written image stays
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= HST_IDLE;
			link.image <= {{SPARE_W{1'b0}}, SEL_OFF, SEL_OFF, {DATA_W{1'b0}}};
			link.write_stb <= 1'b0;
			link.scan_end <= 1'b0;
			alternate_scan_toggle <= 1'b1;
		end else begin
			state <= next_state;
			link.image <= next_image;
			link.write_stb <= next_write_stb;
			link.scan_end <= next_scan_end;
			alternate_scan_toggle <= next_toggle;
		end
	end

	assign busy = (state != HST_IDLE);

endmodule
`default_nettype wire

/* test/dcdwp_asserts.sv */
// Wire checks on the output image link between host and module.
// Assumes one clock and the host as the only driver of the link.
`timescale 1ns/1ps
`default_nettype none
module dcdwp_asserts (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [dcdwp_pkg::IMG_W-1:0] image,
	input wire logic write_stb,
	input wire logic scan_end
);
	import dcdwp_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// Two writes back to back only happen in a pointer scan
	sequence pair_s;
		write_stb ##1 write_stb;
	endsequence
	sequence close_s;
		##[1:2] scan_end;
	endsequence
	// Host writes: spare points stay clear and something is selected
	spare_zero_a: assert property (write_stb |-> image[IMG_W-1:SPARE_LSB] == '0)
		else $error("spare bits set on write");
	one_select_a: assert property (write_stb |-> !(image[SEL1_BIT] && image[SEL2_BIT]))
		else $error("write with no channel selected");
	write_close_a: assert property (write_stb |-> close_s)
		else $error("write not closed by scan end");
	pair_order_a: assert property (pair_s |-> image[SEL2_BIT] == SEL_ON && image[SEL1_BIT] == SEL_OFF)
		else $error("second write of pair not channel 2 only");
	pair_close_a: assert property (pair_s |=> scan_end && !write_stb)
		else $error("more than two writes in a scan");
	// Scan end is a single pulse that follows a write
	end_pulse_a: assert property (scan_end |=> !scan_end)
		else $error("scan end longer than one cycle");
	end_after_a: assert property (scan_end |-> $past(write_stb))
		else $error("scan end without a write");
	// Image may only move together with a write strobe
	image_hold_a: assert property ($changed(image) |-> write_stb)
		else $error("image changed without a write");
endmodule
`default_nettype wire

/* test/test_dual_channel_dac_write_port.sv */
// Self-checking bench: host and module joined by the image link.
// Assumes a 40 MHz ref_clk; the bench drives only the host user side.
`timescale 1ns/1ps
`default_nettype none
module test_dual_channel_dac_write_port;
	import dcdwp_pkg::*;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic scan_start = 1'b0;
	dcdwp_mode_t mode = DCDWP_MUX;
	logic bcd_format = 1'b0;
	logic [DATA_W-1:0] ch1_value = '0;
	logic [DATA_W-1:0] ch2_value = '0;
	logic busy, alternate_scan_toggle, refresh, ch1_fresh, ch2_fresh, multi_update, spare_set;
	logic [DATA_W-1:0] ch1_code, ch2_code, e1, e2;
	logic [UA_W-1:0] ch1_ua, ch2_ua;
	logic etog, f1, f2, mu;
	int errors = 0;
	int n_checks = 0;
	// Scan table: mode, BCD flag, values, cycles scan_start is held
	dcdwp_mode_t tm [8] = '{DCDWP_MUX, DCDWP_MUX, DCDWP_MUX, DCDWP_MUX,
		DCDWP_POINTER, DCDWP_ONLY1, DCDWP_BOTH, DCDWP_POINTER};
	logic tbcd [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
	logic [DATA_W-1:0] t1 [8] = '{16'hffff, 16'hffff, 16'h9999, 16'h0000,
		16'h5fff, 16'h0001, 16'h7fff, 16'h1234};
	logic [DATA_W-1:0] t2 [8] = '{16'h1234, 16'h0000, 16'h0001, 16'h0250,
		16'h8000, 16'haaaa, 16'h0f0f, 16'h5678};
	int th [8] = '{1, 2, 1, 1, 1, 1, 1, 2};
	// 25 ns period
	always #12.5 ref_clk = ~ref_clk;
	dcdwp_if u_dcdwp_if ();
	dcdwp_host u_dcdwp_host (.ref_clk(ref_clk), .rstn(rstn), .link(u_dcdwp_if.host),
		.scan_start(scan_start), .mode(mode), .bcd_format(bcd_format), .ch1_value(ch1_value),
		.ch2_value(ch2_value), .busy(busy), .alternate_scan_toggle(alternate_scan_toggle));
	dcdwp_device #(.CURRENT_VARIANT(1'b1)) u_dcdwp_device (.ref_clk(ref_clk), .rstn(rstn),
		.link(u_dcdwp_if.device), .ch1_code(ch1_code), .ch2_code(ch2_code), .ch1_ua(ch1_ua),
		.ch2_ua(ch2_ua), .refresh(refresh), .ch1_fresh(ch1_fresh), .ch2_fresh(ch2_fresh),
		.multi_update(multi_update), .spare_set(spare_set));
	dcdwp_asserts u_dcdwp_asserts (.ref_clk(ref_clk), .rstn(rstn), .image(u_dcdwp_if.image),
		.write_stb(u_dcdwp_if.write_stb), .scan_end(u_dcdwp_if.scan_end));
	// Compare helpers count every check
	task automatic chk_word(input string name, input logic [DATA_W-1:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic chk_bit(input string name, input logic seen, exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %b seen %b", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Reference models, kept apart from the host's own converter
	function automatic logic [DATA_W-1:0] bin(input logic [DATA_W-1:0] v);
		return ((v[15:12] * BCD_RADIX + v[11:8]) * BCD_RADIX + v[7:4]) * BCD_RADIX + v[3:0];
	endfunction
	function automatic logic [UA_W-1:0] ua(input logic [DATA_W-1:0] c);
		logic [31:0] t;
		t = UA_ZERO + (UA_SPAN * c) / CODE_MAX;
		return t[UA_W-1:0];
	endfunction
	task automatic chk_all();
		chk_word("ch1_code", ch1_code, e1);
		chk_word("ch2_code", ch2_code, e2);
		chk_word("ch1_ua", {1'b0, ch1_ua}, {1'b0, ua(e1)});
		chk_word("ch2_ua", {1'b0, ch2_ua}, {1'b0, ua(e2)});
		chk_bit("ch1_fresh", ch1_fresh, f1);
		chk_bit("ch2_fresh", ch2_fresh, f2);
		chk_bit("multi_update", multi_update, mu);
		chk_bit("spare_set", spare_set, 1'b0);
		chk_bit("toggle", alternate_scan_toggle, etog);
	endtask
	// Reset may also land mid-run; every output but refresh and busy must return to its idle value
	task automatic do_reset();
		rstn = 1'b0;
		repeat (2) @(negedge ref_clk);
		rstn = 1'b1;
		{e1, e2, f1, f2, mu, etog} = {32'h0, 4'h1};
		chk_all();
		chk_word("image_sel", {14'h0, u_dcdwp_if.image[SEL2_BIT:SEL1_BIT]}, 16'h0003);
	endtask
	// One host scan; a hold of 2 offers scan_start again while busy
	task automatic scan(input dcdwp_mode_t m, input logic bcd, input logic [DATA_W-1:0] v1, v2,
		input int hold);
		int k;
		logic [DATA_W-1:0] b1, b2;
		b1 = bcd ? bin(v1) : v1;
		b2 = bcd ? bin(v2) : v2;
		mode = m;
		bcd_format = bcd;
		ch1_value = v1;
		ch2_value = v2;
		scan_start = 1'b1;
		repeat (hold) @(negedge ref_clk);
		scan_start = 1'b0;
		for (k = 0; k < 8 && refresh !== 1'b1; k++) @(negedge ref_clk);
		chk_bit("refresh", refresh, 1'b1);
		f1 = (m == DCDWP_MUX) ? etog : 1'b1;
		f2 = m == DCDWP_POINTER || m == DCDWP_BOTH || (m == DCDWP_MUX && !etog);
		mu = m == DCDWP_POINTER || m == DCDWP_BOTH;
		if (f1)
			e1 = b1;
		if (f2)
			e2 = (m == DCDWP_BOTH) ? b1 : b2;
		etog = ~etog;
		chk_all();
		@(negedge ref_clk);
		chk_bit("refresh", refresh, 1'b0);
		chk_bit("busy", busy, 1'b0);
	endtask
	// Main sequence
	initial begin
		int i;
		do_reset();
		for (i = 0; i < 8; i++)
			scan(tm[i], tbcd[i], t1[i], t2[i], th[i]);
		do_reset();
		scan(DCDWP_MUX, 1'b0, 16'h0042, 16'h0043, 1);
		stop_test();
	end
	// Watchdog: the run needs under 100 cycles, allow 400
	initial begin
		#10000;
		errors++;
		stop_test();
	end
endmodule
`default_nettype wire
